/* hw/valve_actuator_command_control.sv */
`timescale 1ns/1ps
`include "valve_map.svh"

module valve_actuator_command_control import valve_pkg::*; #(
    parameter int unsigned WINDOW_CYCLES = `WINDOW_CYCLES,
    parameter int unsigned STALL_CYCLES = `STALL_CYCLES,
    parameter logic [15:0] POS_TOL = 16'h0004,
    parameter logic [15:0] V_LOW = 16'h0CCC,
    parameter logic [15:0] V_FULL = 16'h3FFF,
    parameter logic [15:0] I_LOW = 16'h0CCC,
    parameter logic [15:0] I_FULL = 16'h3FFF
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic onoff_unit_i,
    input wire logic open_contact_i,
    input wire logic close_contact_i,
    input wire logic [15:0] analog_value_i,
    input wire logic analog_valid_i,
    input wire logic [15:0] travel_i,
    input wire logic open_stop_i,
    input wire logic close_stop_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic motor_open_o,
    output logic motor_close_o,
    output logic stall_fault_o,
    output logic calibrating_o
);
    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic [15:0] position_command, motion_deadband, zero_point, span_point;
    logic control_source_select, input_mode_select;
    logic [15:0] next_position_command, next_motion_deadband, next_zero_point, next_span_point;
    logic next_control_source_select, next_input_mode_select;
    logic [15:0] next_rdata;
    logic cal_req, wr_one;
    logic [15:0] analog_seen;

    // Words arrive decoded; 9600 baud even-parity framing sits outside [R19]
    // Invalid input reads as zero so software can spot a dead loop
    assign analog_seen = analog_valid_i ? analog_value_i : 16'h0000; // [R17]
    assign wr_one = reg_wr_i && (reg_wdata_i == `TRIGGER_VALUE);

    always_comb begin
        next_position_command = position_command;
        next_motion_deadband = motion_deadband;
        next_control_source_select = control_source_select;
        next_input_mode_select = input_mode_select;
        next_zero_point = zero_point;
        next_span_point = span_point;
        cal_req = 1'b0;
        if (reg_wr_i) begin
            case (reg_addr_i)
                `REG_POSITION_COMMAND: next_position_command = reg_wdata_i;
                `REG_CONTROL_SOURCE_SELECT: begin
                    next_control_source_select = reg_wdata_i[`SEL_BIT]; // [R1]
                end
                `REG_MOTION_DEADBAND: next_motion_deadband = reg_wdata_i;
                `REG_INPUT_MODE_SELECT: next_input_mode_select = reg_wdata_i[`SEL_BIT];
                default: ;
            endcase
        end
        // Triggers hold no state: one write of 1 is one action; a calibrate write mid-stroke is dropped
        if (wr_one && reg_addr_i == `REG_CALIBRATE_TRIGGER) begin
            cal_req = 1'b1; // [R5] [R20]
        end
        if (wr_one && reg_addr_i == `REG_ANALOG_ZERO_CAPTURE) begin
            next_zero_point = analog_seen; // [R11] [R20]
        end
        if (wr_one && reg_addr_i == `REG_ANALOG_SPAN_CAPTURE) begin
            next_span_point = analog_seen; // [R12] [R20]
        end
        case (reg_addr_i)
            `REG_POSITION_COMMAND: next_rdata = position_command;
            `REG_ANALOG_INPUT_VALUE: next_rdata = analog_seen; // [R17]
            `REG_CONTROL_SOURCE_SELECT: next_rdata = {15'h0000, control_source_select};
            `REG_MOTION_DEADBAND: next_rdata = motion_deadband;
            `REG_INPUT_MODE_SELECT: next_rdata = {15'h0000, input_mode_select};
            default: next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            position_command <= `POSITION_RST;
            motion_deadband <= `DEADBAND_RST;
            control_source_select <= `SOURCE_RST;
            input_mode_select <= `MODE_RST;
            zero_point <= `ZERO_RST;
            span_point <= `SPAN_RST;
            reg_rdata_o <= 16'h0000;
            reg_rvalid_o <= 1'b0;
        end else begin
            position_command <= next_position_command;
            motion_deadband <= next_motion_deadband;
            control_source_select <= next_control_source_select;
            input_mode_select <= next_input_mode_select;
            zero_point <= next_zero_point;
            span_point <= next_span_point;
            reg_rdata_o <= reg_rd_i ? next_rdata : 16'h0000;
            reg_rvalid_o <= reg_rd_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command selection, result in percent travel
    logic [6:0] cmd_pct, next_contact_pct, contact_pct, reg_pct, analog_pct;
    logic [15:0] a_num, a_den;
    logic [22:0] a_scaled;

    // Span below zero point reads as no range and commands closed
    always_comb begin
        a_num = (analog_seen > zero_point) ? analog_seen - zero_point : 16'h0000;
        a_den = (span_point > zero_point) ? span_point - zero_point : 16'h0000;
        if (a_den == 16'h0000) begin
            a_scaled = 23'h000000;
        end else begin
            a_scaled = 23'(({7'h00, a_num} * 23'(`PCT_FULL)) / {7'h00, a_den}); // [R10]
        end
        analog_pct = (a_scaled > 23'(`PCT_FULL)) ? `PCT_FULL : a_scaled[6:0]; // [R10]
        // Positioning units read the register as percent, clamped at full open
        if (position_command > 16'(`PCT_FULL)) begin
            reg_pct = `PCT_FULL; // [R13]
        end else begin
            reg_pct = position_command[6:0]; // [R13]
        end
        if (onoff_unit_i) begin
            reg_pct = (position_command < 16'(`PCT_HALF)) ? 7'h00 : `PCT_FULL; // [R2]
        end
        next_contact_pct = contact_pct;
        if (input_mode_select) begin
            next_contact_pct = open_contact_i ? `PCT_FULL : 7'h00; // [R4] [R15]
        end else if (open_contact_i && !close_contact_i) begin
            next_contact_pct = `PCT_FULL; // [R4] [R14]
        end else if (close_contact_i && !open_contact_i) begin
            next_contact_pct = 7'h00; // [R14]
        end
        if (!control_source_select) begin
            cmd_pct = reg_pct; // [R1]
        end else if (onoff_unit_i) begin
            cmd_pct = contact_pct; // [R1]
        end else begin
            cmd_pct = analog_pct; // [R1] [R3]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-on gesture detection
    gesture_e gesture, next_gesture;
    logic [31:0] window_cnt, next_window_cnt;
    logic in_window, arm_cond, fire_cond, gesture_fire;
    logic [15:0] low_lvl, full_lvl;

    // The window runs once per reset release and never restarts
    assign in_window = window_cnt < WINDOW_CYCLES; // [R6]
    assign low_lvl = input_mode_select ? I_LOW : V_LOW; // [R3]
    assign full_lvl = input_mode_select ? I_FULL : V_FULL; // [R3]

    always_comb begin
        if (onoff_unit_i && !input_mode_select) begin
            arm_cond = open_contact_i; // [R7]
            fire_cond = close_contact_i; // [R7]
        end else if (onoff_unit_i) begin
            arm_cond = open_contact_i; // [R8]
            fire_cond = !open_contact_i; // [R8]
        end else begin
            arm_cond = analog_valid_i && analog_value_i >= full_lvl; // [R9]
            fire_cond = analog_valid_i && analog_value_i <= low_lvl; // [R9]
        end
        next_window_cnt = in_window ? window_cnt + 32'h00000001 : window_cnt;
        next_gesture = gesture;
        gesture_fire = 1'b0;
        case (gesture)
            GEST_WAIT: begin
                if (in_window && control_source_select && arm_cond) begin
                    next_gesture = GEST_ARMED;
                end
            end
            GEST_ARMED: begin
                if (!in_window) begin
                    next_gesture = GEST_DONE; // [R6]
                end else if (fire_cond) begin
                    next_gesture = GEST_DONE;
                    gesture_fire = 1'b1; // [R7] [R8] [R9]
                end
            end
            GEST_DONE: next_gesture = GEST_DONE;
            default: next_gesture = GEST_DONE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            gesture <= GEST_WAIT;
            window_cnt <= 32'h00000000;
            contact_pct <= 7'h00;
        end else begin
            gesture <= next_gesture;
            window_cnt <= next_window_cnt;
            contact_pct <= next_contact_pct;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Calibration stroke, stall supervision and motor drive
    cal_state_e cal, next_cal;
    logic [15:0] open_end, close_end, next_open_end, next_close_end;
    logic [15:0] target, last_travel, next_last_travel;
    logic [22:0] tgt_off;
    logic [31:0] stall_cnt, next_stall_cnt;
    logic [6:0] stall_pct, next_stall_pct, pct_diff;
    logic next_stall, next_open, next_close, next_calibrating, hold;

    // End points are only rewritten by a stroke, never by a mode change
    always_comb begin
        tgt_off = 23'(({7'h00, (open_end > close_end) ? open_end - close_end : 16'h0000} *
                  {16'h0000, cmd_pct}) / 23'(`PCT_FULL));
        target = close_end + tgt_off[15:0]; // [R18]
        pct_diff = (cmd_pct > stall_pct) ? cmd_pct - stall_pct : stall_pct - cmd_pct;
        hold = gesture == GEST_ARMED; // [R7] [R8] [R9]
        next_cal = cal;
        next_open_end = open_end;
        next_close_end = close_end;
        next_open = 1'b0;
        next_close = 1'b0;
        next_stall = stall_fault_o;
        next_stall_pct = stall_pct;
        next_last_travel = travel_i;
        next_stall_cnt = 32'h00000000;
        case (cal)
            CAL_IDLE: begin
                if (cal_req || gesture_fire) begin
                    next_cal = CAL_OPEN; // [R5]
                    next_stall = 1'b0;
                end else if (stall_fault_o) begin
                    // Motor stays off until the demand moves past the deadband
                    if ({9'h000, pct_diff} > motion_deadband) begin
                        next_stall = 1'b0; // [R16]
                    end
                end else if (!hold) begin
                    // One bit wider so a target near full scale cannot wrap into a close
                    next_open = 17'(travel_i) + 17'(POS_TOL) < 17'(target);
                    next_close = 17'(travel_i) > 17'(target) + 17'(POS_TOL);
                    if ((next_open || next_close) && travel_i == last_travel) begin
                        next_stall_cnt = stall_cnt + 32'h00000001;
                    end
                    if (stall_cnt >= STALL_CYCLES - 1) begin
                        next_open = 1'b0; // [R16]
                        next_close = 1'b0;
                        next_stall = 1'b1; // [R16]
                        next_stall_pct = cmd_pct; // [R16]
                    end
                end
            end
            CAL_OPEN: begin
                next_open = !open_stop_i; // [R5]
                if (open_stop_i) begin
                    next_open_end = travel_i; // [R18]
                    next_cal = CAL_CLOSE;
                end
            end
            CAL_CLOSE: begin
                next_close = !close_stop_i; // [R5]
                if (close_stop_i) begin
                    next_close_end = travel_i; // [R18]
                    next_cal = CAL_IDLE; // [R5]
                end
            end
            default: next_cal = CAL_IDLE;
        endcase
        next_calibrating = next_cal != CAL_IDLE;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            cal <= CAL_IDLE;
            open_end <= 16'hFFFF;
            close_end <= 16'h0000;
            stall_cnt <= 32'h00000000;
            stall_pct <= 7'h00;
            last_travel <= 16'h0000;
            stall_fault_o <= 1'b0;
            motor_open_o <= 1'b0;
            motor_close_o <= 1'b0;
            calibrating_o <= 1'b0;
        end else begin
            cal <= next_cal;
            open_end <= next_open_end;
            close_end <= next_close_end;
            stall_cnt <= next_stall_cnt;
            stall_pct <= next_stall_pct;
            last_travel <= next_last_travel;
            stall_fault_o <= next_stall;
            motor_open_o <= next_open;
            motor_close_o <= next_close;
            calibrating_o <= next_calibrating;
        end
    end
endmodule

/* hw/valve_map.svh */
// What this block does
// [R1] Control source 0 follows the position register; 1 follows the local inputs.
// [R2] On/off unit under register control: 0-49 closes fully, 50-100 opens fully.
// [R3] Positioning unit, local: input mode 0 is 1-5 V, 1 is 4-20 mA.
// [R4] On/off unit, local: input mode 0 is dual contact, 1 is single contact.
// [R5] Writing 1 to the calibrate trigger strokes open, closed, then back to command.
// [R6] Local calibration gesture counts only if finished within 15 s of power-on.
// [R7] Dual contact in window: open side arms silently, close side runs calibration.
// [R8] Single contact in window: closing arms silently, opening runs calibration.
// [R9] Analog in window: full scale arms silently, low scale runs calibration.
// [R10] Analog command scales linearly: low end point closed, high end point open.
// [R11] Writing 1 to the zero capture stores the analog value as 0 percent.
// [R12] Writing 1 to the span capture stores the analog value as 100 percent.
// [R13] Positioning unit under register control takes the position as percent travel.
// [R14] Dual contact: open-side contact opens the valve, close-side contact closes it.
// [R15] Single contact: closed contact opens the valve, open contact closes it.
// [R16] Unreachable target stops motor and flags stall; retry after change beyond deadband.
// [R17] Analog value register shows the input, zero when the input is not valid.
// [R18] Calibration data survives control method changes without recalibration.
// [R19] Serial link defaults to 9600 baud even parity; master matches it. The framing is outside this block; words arrive decoded.
// [R20] Trigger registers self-clear; each write of 1 starts exactly one action. A calibrate write during a stroke starts none here.
`ifndef VALVE_MAP_SVH
`define VALVE_MAP_SVH

`define REG_POSITION_COMMAND 16'h9C41
`define REG_CALIBRATE_TRIGGER 16'h9C43
`define REG_ANALOG_ZERO_CAPTURE 16'h9C44
`define REG_ANALOG_SPAN_CAPTURE 16'h9C45
`define REG_ANALOG_INPUT_VALUE 16'h9C59
`define REG_CONTROL_SOURCE_SELECT 16'h9C62
`define REG_MOTION_DEADBAND 16'h9C64
`define REG_INPUT_MODE_SELECT 16'h9C6B

`define SEL_BIT 0
`define TRIGGER_VALUE 16'h0001
`define POSITION_RST 16'h0000
`define SOURCE_RST 1'b0
`define MODE_RST 1'b0
`define DEADBAND_RST 16'h0002
`define ZERO_RST 16'h0000
`define SPAN_RST 16'hFFFF

`define PCT_FULL 7'h64
`define PCT_HALF 7'h32
`define CLK_HZ 125000000
`define WINDOW_TIME_S 15
`define STALL_TIME_MS 1000
`define WINDOW_CYCLES (`WINDOW_TIME_S * `CLK_HZ)
`define STALL_CYCLES (`STALL_TIME_MS * (`CLK_HZ / 1000))

`endif

/* hw/valve_pkg.sv */
package valve_pkg;
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_OPEN = 2'b01,
        CAL_CLOSE = 2'b10
    } cal_state_e;

    typedef enum logic [1:0] {
        GEST_WAIT = 2'b00,
        GEST_ARMED = 2'b01,
        GEST_DONE = 2'b10
    } gesture_e;
endpackage

/* tb/valve_actuator_command_control_tb.sv */
`timescale 1ns/1ps
module valve_actuator_command_control_tb;
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, onoff = 1'b0, oc = 1'b0, cc = 1'b0;
    logic avld = 1'b1, jam = 1'b0, rvalid, mo, mc, stall, cal, ostop, cstop;
    logic [15:0] addr = 16'h0000, wdata = 16'h0000, av = 16'h0000, rdata, travel;
    logic [31:0] seed = 32'h0000005B;
    int fails = 0, checked = 0, p;
    int oo[5] = '{49, 50, 0, 100, 49};
    initial forever #4 clk = ~clk;
    valve_actuator_command_control #(.WINDOW_CYCLES(200), .STALL_CYCLES(20))
        valve_actuator_command_control_i (.clk_sys_i(clk), .resetn_i(rstn), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .onoff_unit_i(onoff),
        .open_contact_i(oc), .close_contact_i(cc), .analog_value_i(av), .analog_valid_i(avld),
        .travel_i(travel), .open_stop_i(ostop), .close_stop_i(cstop), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .motor_open_o(mo), .motor_close_o(mc), .stall_fault_o(stall),
        .calibrating_o(cal));
    valve_plant valve_plant_i (.clk_sys_i(clk), .motor_open_i(mo), .motor_close_i(mc),
        .jam_i(jam), .travel_o(travel), .open_stop_o(ostop), .close_stop_o(cstop));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Travel expected for a percent command once the stroke ends are learnt
    function automatic logic [15:0] exp_travel(input int pct);
        return 16'h0100 + 16'(pct * 512 / 100);
    endfunction
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Holding a strobe a second cycle low keeps back-to-back calls clean
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk); #1;
        wr = 1'b0;
        @(posedge clk); #1;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        addr = a;
        rd = 1'b1;
        @(posedge clk); #1;
        rd = 1'b0;
        cmp({15'h0000, rvalid}, 16'h0001);
        cmp(rdata, exp);
        @(posedge clk); #1;
    endtask
    // Motion may lag the command, so idle must last a few cycles
    task automatic settle();
        int q = 0;
        int n = 0;
        repeat (3) @(posedge clk);
        while (q < 4 && n < 3000) begin
            @(posedge clk); #1;
            n++;
            q = (mo === 1'b0 && mc === 1'b0 && cal === 1'b0) ? q + 1 : 0;
        end
    endtask
    task automatic at_pct(input int pct);
        logic [15:0] e = exp_travel(pct);
        if (travel + 16'h0008 >= e && travel <= e + 16'h0008) cmp(travel, travel);
        else cmp(travel, e);
    endtask
    task automatic do_reset(input int n);
        rstn = 1'b0;
        repeat (n) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // Power-on gesture: {close, open, analog} arm then fire; late means window passed
    task automatic gesture(input logic u, input logic m, input logic [17:0] arm,
        input logic [17:0] fire, input logic late);
        int n = 0;
        do_reset(2);
        onoff = u;
        {cc, oc, av} = 18'h00000;
        wr_reg(16'h9C6B, {15'h0000, m});
        wr_reg(16'h9C62, 16'h0001);
        if (late) begin
            repeat (250) @(posedge clk);
            #1;
        end
        {cc, oc, av} = arm;
        repeat (10) @(posedge clk);
        #1 cmp({15'h0000, mo}, {15'h0000, late});
        {cc, oc, av} = fire;
        while (cal !== 1'b1 && n < 6) begin
            @(posedge clk); #1;
            n++;
        end
        cmp({15'h0000, cal}, {15'h0000, !late});
        settle();
        $display("gesture test done");
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        conclude();
    end
    // Main sequence
    initial begin
        do_reset(6);
        av = 16'(rnd() % 32'h3333);
        rd_chk(16'h9C41, 16'h0000);
        rd_chk(16'h9C62, 16'h0000);
        rd_chk(16'h9C6B, 16'h0000);
        rd_chk(16'h9C64, 16'h0002);
        rd_chk(16'h9C43, 16'h0000);
        rd_chk(16'h1234, 16'h0000);
        rd_chk(16'h9C59, av);
        avld = 1'b0;
        rd_chk(16'h9C59, 16'h0000);
        avld = 1'b1;
        $display("register test done");
        wr_reg(16'h9C43, 16'h0001);
        cmp({14'h0000, cal, mo}, 16'h0003);
        wr_reg(16'h9C43, 16'h0001);
        settle();
        at_pct(0);
        wr_reg(16'h9C41, 16'h0001);
        settle();
        cmp({15'h0000, cal}, 16'h0000);
        $display("calibration test done");
        for (int k = 0; k < 4; k++) begin
            p = rnd() % 101;
            wr_reg(16'h9C41, 16'(p));
            settle();
            at_pct(p);
        end
        onoff = 1'b1;
        foreach (oo[i]) begin
            wr_reg(16'h9C41, 16'(oo[i]));
            settle();
            at_pct(oo[i] >= 50 ? 100 : 0);
        end
        $display("register control test done");
        wr_reg(16'h9C62, 16'h0001);
        oc = 1'b1;
        settle();
        at_pct(100);
        {oc, cc} = 2'b01;
        settle();
        at_pct(0);
        wr_reg(16'h9C41, 16'h0064);
        settle();
        at_pct(0);
        cc = 1'b0;
        wr_reg(16'h9C6B, 16'h0001);
        oc = 1'b1;
        settle();
        at_pct(100);
        oc = 1'b0;
        settle();
        at_pct(0);
        onoff = 1'b0;
        av = 16'h0CCC;
        wr_reg(16'h9C44, 16'h0001);
        av = 16'h3FFF;
        wr_reg(16'h9C45, 16'h0001);
        for (int k = 0; k < 4; k++) begin
            av = (k == 0) ? 16'h0CCC : (k == 1) ? 16'h3FFF : (k == 2) ? 16'h2665 :
                16'h0CCC + 16'(rnd() % 32'h3333);
            p = int'(av - 16'h0CCC) * 100 / 13107;
            settle();
            at_pct(p);
        end
        // Changing the input type must keep the captured end points and position
        wr_reg(16'h9C6B, 16'h0000);
        settle();
        at_pct(p);
        $display("local control test done");
        wr_reg(16'h9C62, 16'h0000);
        wr_reg(16'h9C41, 16'h0032);
        settle();
        jam = 1'b1;
        wr_reg(16'h9C41, 16'h005A);
        repeat (26) @(posedge clk);
        #1 cmp({13'h0000, stall, mo, mc}, 16'h0004);
        wr_reg(16'h9C41, 16'h005B);
        repeat (5) @(posedge clk);
        #1 cmp({15'h0000, stall}, 16'h0001);
        jam = 1'b0;
        wr_reg(16'h9C41, 16'h0014);
        settle();
        cmp({15'h0000, stall}, 16'h0000);
        at_pct(20);
        $display("stall test done");
        gesture(1'b1, 1'b0, 18'h10000, 18'h20000, 1'b0);
        gesture(1'b1, 1'b1, 18'h10000, 18'h00000, 1'b0);
        gesture(1'b0, 1'b1, 18'h03FFF, 18'h00CCC, 1'b0);
        gesture(1'b1, 1'b0, 18'h10000, 18'h20000, 1'b1);
        conclude();
    end
endmodule
bind valve_actuator_command_control valve_monitor #(.STALL_CYCLES(20)) valve_monitor_i (.*);

/* tb/valve_monitor.sv */
`timescale 1ns/1ps
// Port-level checks; sees only top-level ports
module valve_monitor #(
    parameter int unsigned STALL_CYCLES = 20
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] analog_value_i,
    input wire logic analog_valid_i,
    input wire logic [15:0] travel_i,
    input wire logic open_stop_i,
    input wire logic close_stop_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic motor_open_o,
    input wire logic motor_close_o,
    input wire logic calibrating_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////////////////////////////
    logic [15:0] prev_travel;
    int unsigned still_cnt;
    // Cycles the motor has driven without the travel moving
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prev_travel <= 16'h0000;
            still_cnt <= 0;
        end else begin
            prev_travel <= travel_i;
            if ((motor_open_o || motor_close_o) && travel_i == prev_travel) begin
                still_cnt <= still_cnt + 1;
            end else begin
                still_cnt <= 0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    // Opposed drives would fight the gear train
    motor_exclusive_a: assert property (!(motor_open_o && motor_close_o))
        else $error("both motor drives on");
    read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o && $past(reg_rd_i))
        else $error("read strobe not answered");
    wo_read_zero_a: assert property (reg_rd_i && reg_addr_i == 16'h9C43 |=>
        reg_rdata_o == 16'h0000)
        else $error("write-only register read nonzero");
    analog_read_a: assert property (reg_rd_i && reg_addr_i == 16'h9C59 |=>
        reg_rdata_o == ($past(analog_valid_i) ? $past(analog_value_i) : 16'h0000))
        else $error("analog value read wrong");
    // Each stroke state drives its motor one cycle after it is entered
    cal_start_a: assert property (reg_wr_i && reg_addr_i == 16'h9C43 &&
        reg_wdata_i == 16'h0001 && !calibrating_o |=> calibrating_o ##1
        (calibrating_o && motor_open_o))
        else $error("calibration did not start");
    cal_turn_a: assert property (calibrating_o && motor_open_o && open_stop_i |=>
        !motor_open_o ##1 (motor_close_o && calibrating_o))
        else $error("stroke did not reverse at open stop");
    cal_end_a: assert property (calibrating_o && motor_close_o && close_stop_i |=>
        !calibrating_o && !motor_close_o)
        else $error("stroke did not end at closed stop");
    stall_bound_a: assert property (still_cnt <= STALL_CYCLES + 3)
        else $error("motor kept driving a stuck plug");
endmodule

/* tb/valve_plant.sv */
`timescale 1ns/1ps
// Plug and gear: one count per cycle between two hard stops; jam freezes it
module valve_plant (
    input wire logic clk_sys_i,
    input wire logic motor_open_i,
    input wire logic motor_close_i,
    input wire logic jam_i,
    output logic [15:0] travel_o,
    output logic open_stop_o,
    output logic close_stop_o
);
    initial travel_o = 16'h0100;
    // Stops limit travel even if the drive stays on
    always @(posedge clk_sys_i) begin
        if (!jam_i && motor_open_i && travel_o < 16'h0300) begin
            travel_o <= travel_o + 16'h0001;
        end else if (!jam_i && motor_close_i && travel_o > 16'h0100) begin
            travel_o <= travel_o - 16'h0001;
        end
    end
    assign open_stop_o = travel_o >= 16'h0300;
    assign close_stop_o = travel_o <= 16'h0100;
endmodule
